/* File: hw/ttxi_core.sv */
// teletext insertion: request pulse train, delayed bit sampling, fifo,
// and the insertion window placed after the horizontal sync edge.
// assumes hsync/vsync pulses and field flag synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module ttxi_core #(
    parameter int FIFO_DEPTH = 8,
    parameter int DLY_MAX    = 64
) (
    input  wire logic        core_clk,             // 125 MHz core clock
    input  wire logic        reset_n,              // async reset, active low
    input  wire logic        psel,                 // apb select
    input  wire logic        penable,              // apb access phase
    input  wire logic        pwrite,               // apb write
    input  wire logic [7:0]  paddr,                // apb byte address
    input  wire logic [31:0] pwdata,               // apb write data
    output logic [31:0]      prdata,               // apb read data
    output logic             pready,               // apb ready
    output logic             pslverr,              // apb error
    input  wire logic        hsync_lead,           // leading hsync edge pulse
    input  wire logic        vsync_lead,           // field start pulse
    input  wire logic        field_odd,            // high in odd field
    input  wire logic        teletext_bit_in,      // serial bit from source
    output logic             teletext_request_out, // one pulse per bit
    output logic             insert_active,        // window open
    output logic             insert_bit            // bit to composite/luma
);
    // ------------------------------------------------------------------
    // registers and apb
    // ------------------------------------------------------------------
    logic        en_q;
    logic [1:0]  std_q;
    logic        reqpin_q;
    logic        datpin_q;
    logic [11:0] start_q;
    logic [5:0]  dly_q;
    logic [9:0]  odd_first_q;
    logic [9:0]  odd_last_q;
    logic [9:0]  even_first_q;
    logic [9:0]  even_last_q;
    logic        under_q;
    logic        apb_wr;
    logic        apb_acc;
    logic        apb_hit;

    localparam int LW = $clog2(FIFO_DEPTH + 1);
    logic [LW-1:0] level;
    logic [13:0]   hs_cnt_q;
    logic [9:0]    line_q;
    logic [8:0]    ins_left_q;

    assign apb_acc = psel && penable && !pready;
    assign apb_wr  = psel && penable && pready && pwrite;
    assign apb_hit = (paddr == ttxi_pkg::CTRL_OFS) || (paddr == ttxi_pkg::TIMING_OFS)
                  || (paddr == ttxi_pkg::ODD_OFS) || (paddr == ttxi_pkg::EVEN_OFS)
                  || (paddr == ttxi_pkg::STATUS_OFS);

    // one wait state: answer registered in the first access cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc && !apb_hit;
            prdata  <= 32'h0000_0000;
            if (apb_acc && !pwrite) begin
                case (paddr)
                    ttxi_pkg::CTRL_OFS: begin
                        prdata <= {27'h0, datpin_q, reqpin_q, std_q, en_q};
                    end
                    ttxi_pkg::TIMING_OFS: begin
                        prdata <= {10'h0, dly_q, 4'h0, start_q};
                    end
                    ttxi_pkg::ODD_OFS: begin
                        prdata <= {6'h0, odd_last_q, 6'h0, odd_first_q};
                    end
                    ttxi_pkg::EVEN_OFS: begin
                        prdata <= {6'h0, even_last_q, 6'h0, even_first_q};
                    end
                    ttxi_pkg::STATUS_OFS: begin
                        prdata[9:0]                    <= line_q;
                        prdata[ttxi_pkg::ST_FIELD_BIT]  <= field_odd;
                        prdata[ttxi_pkg::ST_ACTIVE_BIT] <= insert_active;
                        prdata[ttxi_pkg::ST_LEVEL_LSB +: 4] <= 4'(level);
                        prdata[ttxi_pkg::ST_UNDER_BIT]  <= under_q;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q         <= ttxi_pkg::CTRL_RST[ttxi_pkg::CTRL_EN_BIT];
            std_q        <= ttxi_pkg::CTRL_RST[ttxi_pkg::CTRL_STD_LSB +: 2];
            reqpin_q     <= ttxi_pkg::CTRL_RST[ttxi_pkg::CTRL_REQPIN];
            datpin_q     <= ttxi_pkg::CTRL_RST[ttxi_pkg::CTRL_DATPIN];
            start_q      <= ttxi_pkg::START_RST;
            dly_q        <= ttxi_pkg::DLY_RST;
            odd_first_q  <= ttxi_pkg::FIRST_RST;
            odd_last_q   <= ttxi_pkg::LAST_RST;
            even_first_q <= ttxi_pkg::FIRST_RST;
            even_last_q  <= ttxi_pkg::LAST_RST;
        end else if (apb_wr) begin
            case (paddr)
                ttxi_pkg::CTRL_OFS: begin
                    en_q     <= pwdata[ttxi_pkg::CTRL_EN_BIT];
                    std_q    <= pwdata[ttxi_pkg::CTRL_STD_LSB +: 2];
                    reqpin_q <= pwdata[ttxi_pkg::CTRL_REQPIN];
                    datpin_q <= pwdata[ttxi_pkg::CTRL_DATPIN];
                end
                ttxi_pkg::TIMING_OFS: begin
                    start_q <= pwdata[ttxi_pkg::TIM_START_LSB +: 12];
                    dly_q   <= pwdata[ttxi_pkg::TIM_DLY_LSB +: 6];
                end
                ttxi_pkg::ODD_OFS: begin
                    odd_first_q <= pwdata[9:0];
                    odd_last_q  <= pwdata[ttxi_pkg::LINE_LAST_LSB +: 10];
                end
                ttxi_pkg::EVEN_OFS: begin
                    even_first_q <= pwdata[9:0];
                    even_last_q  <= pwdata[ttxi_pkg::LINE_LAST_LSB +: 10];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // line timing and standard selection
    // ------------------------------------------------------------------
    logic             line_ok;
    logic             run;
    logic [8:0]       nbits;
    logic [13:0]      ins_start;
    logic [ttxi_pkg::NCO_W-1:0] inc;

    // pins unassigned means the source is not wired in: treat as disabled
    assign run = en_q && reqpin_q && datpin_q;
    assign line_ok = field_odd ? (line_q >= odd_first_q && line_q <= odd_last_q)
                               : (line_q >= even_first_q && line_q <= even_last_q);

    always_comb begin
        case (ttxi_pkg::ttxi_std_t'(std_q))
            ttxi_pkg::TTXI_PAL: begin
                nbits     = ttxi_pkg::BITS_PAL;
                ins_start = ttxi_pkg::INS_PAL_CYC;
                inc       = ttxi_pkg::INC_PAL;
            end
            ttxi_pkg::TTXI_NABTS: begin
                nbits     = ttxi_pkg::BITS_NABTS;
                ins_start = ttxi_pkg::INS_NTSC_CYC;
                inc       = ttxi_pkg::INC_NTSC;
            end
            default: begin
                nbits     = ttxi_pkg::BITS_WST;
                ins_start = ttxi_pkg::INS_NTSC_CYC;
                inc       = ttxi_pkg::INC_NTSC;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_cnt_q <= '0;
            line_q   <= '0;
        end else begin
            if (hsync_lead) begin
                hs_cnt_q <= '0;
                line_q   <= vsync_lead ? 10'h001 : line_q + 10'h001;
            end else begin
                if (vsync_lead) begin
                    line_q <= '0;
                end
                if (hs_cnt_q != 14'h3FFF) begin
                    hs_cnt_q <= hs_cnt_q + 14'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // request pulse train
    // ------------------------------------------------------------------
    logic [8:0]               req_left_q;
    logic [ttxi_pkg::NCO_W:0] req_nco_q;
    logic [DLY_MAX-1:0]       req_pipe_q;
    logic [LW-1:0]            pend_q;
    logic                     fire;
    logic                     sample;
    logic                     room;
    logic                     fifo_out_valid;
    logic                     fifo_data;
    logic                     pop;

    // requests are throttled so every outstanding bit has a fifo slot
    assign room   = ({1'b0, level} + {1'b0, pend_q}) < (LW + 1)'(FIFO_DEPTH);
    assign fire   = (req_left_q != '0) && req_nco_q[ttxi_pkg::NCO_W] && room;
    assign sample = req_pipe_q[dly_q] && !hsync_lead;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_left_q <= '0;
            req_nco_q  <= '0;
        end else if (hsync_lead || !run) begin
            req_left_q <= '0;
            req_nco_q  <= '0;
        end else if (hs_cnt_q == {2'b00, start_q} && line_ok) begin
            req_left_q <= nbits;
            req_nco_q  <= {1'b1, {ttxi_pkg::NCO_W{1'b0}}};
        end else if (req_left_q != '0) begin
            // a stalled carry is held until the fifo has room
            if (!req_nco_q[ttxi_pkg::NCO_W] || room) begin
                req_nco_q <= {1'b0, req_nco_q[ttxi_pkg::NCO_W-1:0]} + {1'b0, inc};
            end
            if (fire) begin
                req_left_q <= req_left_q - 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_pipe_q           <= '0;
            teletext_request_out <= 1'b0;
            pend_q               <= '0;
        end else begin
            teletext_request_out <= fire;
            req_pipe_q <= hsync_lead ? '0 : {req_pipe_q[DLY_MAX-2:0], fire};
            if (hsync_lead) begin
                pend_q <= '0;
            end else begin
                pend_q <= pend_q + LW'(fire) - LW'(sample);
            end
        end
    end

    ttxi_fifo #(
        .W (1),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clr       (hsync_lead),
        .in_valid  (sample),
        .in_ready  (),
        .in_data   (teletext_bit_in),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_data),
        .level     (level)
    );

    // ------------------------------------------------------------------
    // insertion window
    // ------------------------------------------------------------------
    logic [ttxi_pkg::NCO_W:0] ins_nco_q;
    logic                     ins_tick;

    assign ins_tick = (ins_left_q != '0) && ins_nco_q[ttxi_pkg::NCO_W];
    assign pop      = ins_tick;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ins_left_q    <= '0;
            ins_nco_q     <= '0;
            insert_active <= 1'b0;
            insert_bit    <= 1'b0;
        end else begin
            if (hsync_lead || !run) begin
                ins_left_q <= '0;
                ins_nco_q  <= '0;
            end else if (hs_cnt_q == ins_start && line_ok) begin
                ins_left_q <= nbits;
                ins_nco_q  <= {1'b1, {ttxi_pkg::NCO_W{1'b0}}};
            end else if (ins_left_q != '0) begin
                ins_nco_q <= {1'b0, ins_nco_q[ttxi_pkg::NCO_W-1:0]} + {1'b0, inc};
                if (ins_tick) begin
                    ins_left_q <= ins_left_q - 9'h001;
                end
            end
            insert_active <= (ins_left_q != '0) && run;
            if (ins_tick) begin
                insert_bit <= fifo_out_valid && fifo_data;
            end
        end
    end

    // underrun is sticky; write one to clear, a new underrun wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            under_q <= 1'b0;
        end else if (ins_tick && !fifo_out_valid) begin
            under_q <= 1'b1;
        end else if (apb_wr && paddr == ttxi_pkg::STATUS_OFS
                     && pwdata[ttxi_pkg::ST_UNDER_BIT]) begin
            under_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic [9:0] req_cnt_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_cnt_q <= '0;
        end else begin
            req_cnt_q <= hsync_lead ? '0 : req_cnt_q + 10'(fire);
        end
    end

    sequence win_hit_s;
        hs_cnt_q == ins_start && line_ok && run && !hsync_lead;
    endsequence

    sequence win_open_s;
        ##1 ins_left_q == nbits ##1 insert_active;
    endsequence

    window_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        win_hit_s |-> win_open_s)
        else $error("window not opened at insertion start");

    closed_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !en_q |=> !insert_active)
        else $error("window open while insertion disabled");

    pulse_single_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        teletext_request_out |=> !teletext_request_out)
        else $error("request pulse longer than one cycle");

    sample_delay_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fire && dly_q == 6'h01 && !hsync_lead) ##1 !hsync_lead && $stable(dly_q)
        |=> sample)
        else $error("bit not sampled two cycles after request");

    req_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        fire |-> hs_cnt_q > {2'b00, start_q})
        else $error("request before programmed start position");

    req_span_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        teletext_request_out |-> $past(run))
        else $error("request issued while insertion not running");

    req_count_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        req_cnt_q <= {1'b0, ttxi_pkg::BITS_PAL})
        else $error("more requests in a line than the window holds");

    pal_bits_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (win_hit_s and std_q == 2'b00) |=> ins_left_q == ttxi_pkg::BITS_PAL)
        else $error("pal window not loaded with 360 bits");

    ntsc_bits_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (win_hit_s and std_q == 2'b10) |=> ins_left_q == ttxi_pkg::BITS_NABTS)
        else $error("nabts window not loaded with 288 bits");

    odd_span_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (field_odd && line_q > odd_last_q) |-> !line_ok)
        else $error("odd line outside span accepted");

    fifo_room_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        ({1'b0, level} + {1'b0, pend_q}) <= (LW + 1)'(FIFO_DEPTH))
        else $error("outstanding bits exceed fifo depth");

    apb_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer later than one wait state");

endmodule // ttxi_core
`default_nettype wire

/* File: pkg/ttxi_pkg.sv */
// constants for the teletext insertion block: register map, field layout,
// window and bit-rate figures; assumes a 125 MHz core clock.
package ttxi_pkg;

    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] TIMING_OFS = 8'h04;
    localparam logic [7:0] ODD_OFS    = 8'h08;
    localparam logic [7:0] EVEN_OFS   = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_STD_LSB   = 1;
    localparam int CTRL_REQPIN    = 3;
    localparam int CTRL_DATPIN    = 4;
    localparam int TIM_START_LSB  = 0;
    localparam int TIM_DLY_LSB    = 16;
    localparam int LINE_LAST_LSB  = 16;
    localparam int ST_FIELD_BIT   = 16;
    localparam int ST_ACTIVE_BIT  = 17;
    localparam int ST_LEVEL_LSB   = 20;
    localparam int ST_UNDER_BIT   = 24;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [11:0] START_RST  = 12'h100;
    localparam logic [5:0]  DLY_RST    = 6'h02;
    localparam logic [9:0]  FIRST_RST  = 10'h007;
    localparam logic [9:0]  LAST_RST   = 10'h016;

    // --------------------------------------------------------------
    // standards and timing
    // --------------------------------------------------------------
    typedef enum logic [1:0] {TTXI_PAL, TTXI_WST, TTXI_NABTS, TTXI_RSVD} ttxi_std_t;

    localparam longint CLK_HZ       = 125000000;
    localparam longint RATE_PAL_BPS = 6937500;
    localparam longint RATE_NTSC_BPS = 5727200;
    localparam int     NCO_W        = 16;
    localparam logic [NCO_W-1:0] INC_PAL  = NCO_W'(RATE_PAL_BPS * 65536 / CLK_HZ);
    localparam logic [NCO_W-1:0] INC_NTSC = NCO_W'(RATE_NTSC_BPS * 65536 / CLK_HZ);

    localparam longint T_INS_PAL_NS  = 9780;
    localparam longint T_INS_NTSC_NS = 10500;
    localparam logic [13:0] INS_PAL_CYC  = 14'(T_INS_PAL_NS * CLK_HZ / 1000000000);
    localparam logic [13:0] INS_NTSC_CYC = 14'(T_INS_NTSC_NS * CLK_HZ / 1000000000);

    localparam logic [8:0] BITS_PAL   = 9'h168;
    localparam logic [8:0] BITS_WST   = 9'h128;
    localparam logic [8:0] BITS_NABTS = 9'h120;

endpackage

/* File: hw/ttxi_fifo.sv */
// small synchronous fifo with valid/ready on both sides and a flush.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ttxi_fifo #(
    parameter int W = 1,
    parameter int D = 8
) (
    input  wire logic                 core_clk,  // core clock
    input  wire logic                 reset_n,   // async reset, active low
    input  wire logic                 clr,       // synchronous flush
    input  wire logic                 in_valid,  // write request
    output logic                      in_ready,  // room available
    input  wire logic [W-1:0]         in_data,   // write data
    output logic                      out_valid, // data available
    input  wire logic                 out_ready, // read acknowledge
    output logic [W-1:0]              out_data,  // head word
    output logic [$clog2(D+1)-1:0]    level      // words held
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != CW'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clr) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule // ttxi_fifo
`default_nettype wire

/* File: test/ttxi_src_model.sv */
// teletext bit source model: one fresh bit for every request pulse.
// assumes request pulses on core_clk, spaced wider than the pipeline delay.
`timescale 1ns/1ns
`default_nettype none
module ttxi_src_model (
    input  wire logic       core_clk, // core clock
    input  wire logic       reset_n,  // async reset, active low
    input  wire logic       request,  // request pulse from the block
    input  wire logic [5:0] dly,      // source pipeline delay in cycles
    output logic            bit_out   // serial bit to the block
);
    logic [63:0] pend_q;
    logic [63:0] win;
    logic        cur_q;
    logic        nxt_q;
    logic        val;
    // the bit owed to a request waits in nxt_q, so a zero delay shows it in the request cycle
    assign win     = {pend_q[62:0], request};
    assign val     = request ? nxt_q : cur_q;
    // off the sample cycle the line shows the inverse, so a mistimed sample is caught
    assign bit_out = win[dly] ? val : ~val;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= '0;
            cur_q  <= 1'b0;
            nxt_q  <= 1'b0;
        end else begin
            pend_q <= {pend_q[62:0], request};
            if (request) begin
                cur_q <= nxt_q;
                nxt_q <= 1'($urandom);
            end
        end
    end
endmodule // ttxi_src_model
`default_nettype wire

/* File: test/test_teletext_insertion_request.sv */
// bench for the teletext insertion block: apb set-up, line timing, counts.
// assumes the source model file is compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_teletext_insertion_request;
    logic core_clk, reset_n, psel, penable, pwrite, hsync_lead, vsync_lead, field_odd;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, tbit, treq, insert_active, insert_bit;
    logic [5:0]  tdly;
    logic [32:0] exp_q[$];
    int          failures, tests_run, cyc, np, first, act_at, nb, st;
    logic        bits_q[$];
    logic [16:0] bn;
    logic [15:0] binc;
    logic        fresh, was_act;
    ttxi_core u_ttxi_core (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsync_lead(hsync_lead),
        .vsync_lead(vsync_lead), .field_odd(field_odd), .teletext_bit_in(tbit),
        .teletext_request_out(treq), .insert_active(insert_active),
        .insert_bit(insert_bit));
    ttxi_src_model u_ttxi_src_model (.core_clk(core_clk), .reset_n(reset_n),
        .request(treq), .dly(tdly), .bit_out(tbit));
    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask
    task automatic end_sim;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        exp_q.push_back(e);
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (!(pready === 1'b1 && penable) && n < 20);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            end_sim();
        end
    endtask
    // one video line: hsync, optional field start, then the line's counts
    task automatic line(input logic vs, input logic odd, input int p, input int f, input int a);
        @(posedge core_clk);
        hsync_lead <= 1'b1; vsync_lead <= vs; field_odd <= odd;
        @(posedge core_clk);
        hsync_lead <= 1'b0; vsync_lead <= 1'b0;
        repeat (7900) @(posedge core_clk);
        chk("pulses", 32'(np), 32'(p));
        chk("first_request", 32'(first), 32'(f));
        chk("window_open", 32'(act_at), 32'(a));
    endtask
    // --------------------------------------------------------------
    // monitors
    // --------------------------------------------------------------
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk("prdata", prdata, exp_q[0][31:0]);
            chk("pslverr", 32'(pslverr), 32'(exp_q[0][32]));
            void'(exp_q.pop_front());
        end
        if (hsync_lead) begin
            cyc <= 0; np <= 0; first <= 0; act_at <= 0;
            bits_q.delete();
        end else begin
            cyc <= cyc + 1;
            if (treq === 1'b1) np <= np + 1;
            if (treq === 1'b1) bits_q.push_back(u_ttxi_src_model.nxt_q);
            if (treq === 1'b1 && np == 0) first <= cyc + 1;
            if (insert_active === 1'b1 && act_at == 0) act_at <= cyc + 1;
        end
        // bit clock replica: each inserted bit is looked at the cycle after its tick
        if (insert_active === 1'b1 && (!was_act || fresh))
            chk("bit", 32'(insert_bit), bits_q.size() ? 32'(bits_q.pop_front()) : 32'h2);
        fresh   <= (insert_active === 1'b1) && was_act && bn[16];
        bn      <= {1'b0, was_act ? bn[15:0] : binc} + {1'b0, binc};
        was_act <= (insert_active === 1'b1);
    end
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, psel, penable, pwrite, hsync_lead, vsync_lead, field_odd} = '0;
        paddr = '0; pwdata = '0; tdly = 6'h02;
        failures = 0; tests_run = 0; cyc = 0; np = 0; first = 0; act_at = 0;
        bn = '0; binc = '0; fresh = 1'b0; was_act = 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        void'($urandom(32'h32aeea39));
        apb(0, 8'h00, 0, 33'h0_0000_0000);
        apb(0, 8'h04, 0, 33'h0_0002_0100);
        apb(0, 8'h08, 0, 33'h0_0016_0007);
        apb(0, 8'h0C, 0, 33'h0_0016_0007);
        apb(0, 8'h14, 0, 33'h1_0000_0000);
        apb(1, 8'h08, 32'h0002_0002, 33'h0);
        apb(1, 8'h0C, 32'h0001_0001, 33'h0);
        // enable alone, then pins alone: no request, no window
        apb(1, 8'h00, 32'h0000_0001, 33'h0);
        line(1, 0, 0, 0, 0);
        apb(1, 8'h00, 32'h0000_0018, 33'h0);
        line(1, 0, 0, 0, 0);
        // standard code 3 is decoded as world standard
        for (int s = 0; s < 4; s++) begin
            nb = (s == 0) ? 360 : (s == 2) ? 288 : 296;
            st = 100 + ($urandom % 400);
            tdly <= 6'($urandom % 8);
            binc <= (s == 0) ? ttxi_pkg::INC_PAL : ttxi_pkg::INC_NTSC;
            @(posedge core_clk);
            apb(1, 8'h04, (32'(tdly) << 16) | 32'(st), 33'h0);
            apb(0, 8'h04, 0, {1'b0, (32'(tdly) << 16) | 32'(st)});
            apb(1, 8'h00, 32'h19 | (32'(s) << 1), 33'h0);
            a_line(s);
            apb(0, 8'h10, 0, (s == 0) ? 33'h0_0000_0001 : 33'h0_0001_0002);
        end
        end_sim();
    end
    // line 1 of the odd field is outside its span, line 2 inside; line 1 even is inside
    task automatic a_line(input int s);
        int a;
        a = (s == 0) ? int'(ttxi_pkg::INS_PAL_CYC) + 3 : int'(ttxi_pkg::INS_NTSC_CYC) + 3;
        line(1, 1, 0, 0, 0);
        line(0, 1, nb, st + 3, a);
        if (s == 0)
            line(1, 0, nb, st + 3, a);
    endtask
endmodule // test_teletext_insertion_request
`default_nettype wire
